// [rtl/ldu_pkg.sv]
package ldu_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int LDU_XLEN = 64;
    localparam int LDU_IMM_W = 16;
    localparam int LDU_RT_W = 5;
    localparam int LDU_OPC_W = 6;

    // ------------------------------------------------------------
    // Major opcodes of the load group
    // ------------------------------------------------------------
    localparam logic [5:0] LDU_OPC_HALF_U = 6'h25;
    localparam logic [5:0] LDU_OPC_LINK_W = 6'h30;
    localparam logic [5:0] LDU_OPC_LINK_D = 6'h34;
    localparam logic [5:0] LDU_OPC_UPPER = 6'h0F;
    localparam logic [5:0] LDU_OPC_WORD = 6'h23;

    // ------------------------------------------------------------
    // Alignment masks and field positions
    // ------------------------------------------------------------
    localparam logic [2:0] LDU_MASK_HALF = 3'h1;
    localparam logic [2:0] LDU_MASK_WORD = 3'h3;
    localparam logic [2:0] LDU_MASK_DBL = 3'h7;
    localparam logic [2:0] LDU_FLIP_HALF = 3'h6;
    localparam logic [2:0] LDU_FLIP_WORD = 3'h4;
    localparam int LDU_UPPER_SHIFT = 16;
    localparam int LDU_HALF_BITS = 16;
    localparam int LDU_WORD_BITS = 32;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        LDU_ST_IDLE = 4'h1,
        LDU_ST_REQ = 4'h2,
        LDU_ST_WAIT = 4'h4,
        LDU_ST_RESP = 4'h8
    } ldu_state_t;

    typedef enum logic [1:0] {
        LDU_SZ_NONE = 2'h0,
        LDU_SZ_HALF = 2'h1,
        LDU_SZ_WORD = 2'h2,
        LDU_SZ_DBL = 2'h3
    } ldu_size_t;

    typedef enum logic [2:0] {
        LDU_EXC_NONE = 3'h0,
        LDU_EXC_ADDR = 3'h1,
        LDU_EXC_REFILL = 3'h2,
        LDU_EXC_INVALID = 3'h3,
        LDU_EXC_RESERVED = 3'h4
    } ldu_exc_t;

endpackage : ldu_pkg

// [rtl/ldu_addr_gen.sv]
module ldu_addr_gen
    import ldu_pkg::*;
#(
    parameter int XLEN = LDU_XLEN
) (
    input wire logic clk, // Core clock.
    input wire logic rst_b, // Synchronous reset, active low.
    input wire logic [XLEN-1:0] base_val, // Base register contents.
    input wire logic [LDU_IMM_W-1:0] offset, // Signed offset field.
    input wire ldu_size_t size, // Access size.
    output logic [XLEN-1:0] eff_addr, // Effective address.
    output logic misaligned // Address not naturally aligned.
);

    logic [2:0] mask;

    assign eff_addr = base_val
        + {{(XLEN-LDU_IMM_W){offset[LDU_IMM_W-1]}}, offset};

    always_comb begin
        case (size)
            LDU_SZ_HALF: mask = LDU_MASK_HALF;
            LDU_SZ_WORD: mask = LDU_MASK_WORD;
            LDU_SZ_DBL: mask = LDU_MASK_DBL;
            default: mask = 3'h0;
        endcase
    end

    assign misaligned = |(eff_addr[2:0] & mask);

    chk_ea_sum_ok: assert property (
        @(posedge clk) disable iff (!rst_b)
        eff_addr - base_val
            == {{(XLEN-LDU_IMM_W){offset[LDU_IMM_W-1]}}, offset})
        else $error("effective address is not base plus offset");

    chk_align_word_err: assert property (
        @(posedge clk) disable iff (!rst_b)
        (size == LDU_SZ_WORD && eff_addr[1:0] != 2'h0) |-> misaligned)
        else $error("misaligned word access not flagged");

endmodule : ldu_addr_gen

// [rtl/ldu_lane_extract.sv]
module ldu_lane_extract
    import ldu_pkg::*;
#(
    parameter int XLEN = LDU_XLEN
) (
    input wire logic [XLEN-1:0] dw, // Doubleword from memory.
    input wire logic [2:0] addr_low, // Effective address bits 2..0.
    input wire logic big_endian, // CPU byte order high first.
    input wire ldu_size_t size, // Access size.
    output logic [XLEN-1:0] result // Extended register value.
);

    logic [2:0] lane;
    logic [XLEN-1:0] shifted;

    function automatic logic [2:0] lane_flip(ldu_size_t sz, logic be);
        case (sz)
            LDU_SZ_HALF: lane_flip = be ? LDU_FLIP_HALF : 3'h0;
            LDU_SZ_WORD: lane_flip = be ? LDU_FLIP_WORD : 3'h0;
            default: lane_flip = 3'h0;
        endcase
    endfunction : lane_flip

    assign lane = addr_low ^ lane_flip(size, big_endian);
    assign shifted = dw >> {lane, 3'b000};

    always_comb begin
        case (size)
            LDU_SZ_HALF: result = {{(XLEN-LDU_HALF_BITS){1'b0}},
                shifted[LDU_HALF_BITS-1:0]};
            LDU_SZ_WORD: result = {{(XLEN-LDU_WORD_BITS)
                {shifted[LDU_WORD_BITS-1]}}, shifted[LDU_WORD_BITS-1:0]};
            default: result = dw;
        endcase
    end

endmodule : ldu_lane_extract

// [rtl/ldu_core.sv]
module ldu_core
    import ldu_pkg::*;
#(
    parameter int XLEN = LDU_XLEN
) (
    input wire logic clk, // Core clock, 125 MHz.
    input wire logic rst_b, // Synchronous reset, active low.
    input wire logic req_valid, // Load instruction offered.
    output logic req_ready, // Unit idle, takes the instruction.
    input wire logic [LDU_OPC_W-1:0] req_opcode, // Major opcode.
    input wire logic [LDU_RT_W-1:0] req_rt, // Destination register.
    input wire logic [XLEN-1:0] req_base_val, // Base register value.
    input wire logic [LDU_IMM_W-1:0] req_offset, // Offset or immediate.
    input wire logic cpu_byte_order_high_first, // Big-endian CPU.
    output logic mem_req_valid, // Memory access request.
    input wire logic mem_req_ready, // Memory path takes request.
    output logic [XLEN-1:0] mem_vaddr, // Effective address.
    output ldu_size_t mem_size, // Access size.
    output logic mem_no_exclusive, // Miss must not fetch exclusive.
    input wire logic mem_rsp_valid, // Memory answer present.
    input wire logic [XLEN-1:0] mem_rsp_data, // Aligned doubleword.
    input wire logic mem_rsp_refill, // No mapping found.
    input wire logic mem_rsp_invalid, // Mapping marked invalid.
    output logic wb_valid, // Write rt this cycle.
    output logic [LDU_RT_W-1:0] wb_rt, // Destination register.
    output logic [XLEN-1:0] wb_data, // Value for rt.
    output logic exc_valid, // Exception this cycle.
    output ldu_exc_t exc_cause, // Exception cause.
    input wire logic link_clear, // Conditional store clears flag.
    output logic link_flag // Read-modify-write sequence open.
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    ldu_state_t state_reg;
    ldu_state_t state_next;
    ldu_size_t dec_size;
    logic dec_linked;
    logic dec_upper;
    logic dec_known;
    logic [XLEN-1:0] eff_addr;
    logic misaligned;
    logic [XLEN-1:0] lane_result;
    logic [XLEN-1:0] upper_value;
    logic take;

    logic [XLEN-1:0] ea_reg;
    ldu_size_t size_reg;
    logic linked_reg;
    logic be_reg;
    logic [LDU_RT_W-1:0] rt_reg;
    logic [XLEN-1:0] data_reg;
    ldu_exc_t exc_reg;
    logic link_reg;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    always_comb begin
        dec_size = LDU_SZ_NONE;
        dec_linked = 1'b0;
        dec_upper = 1'b0;
        dec_known = 1'b1;
        case (req_opcode)
            LDU_OPC_HALF_U: dec_size = LDU_SZ_HALF;
            LDU_OPC_WORD: dec_size = LDU_SZ_WORD;
            LDU_OPC_LINK_W: begin
                dec_size = LDU_SZ_WORD;
                dec_linked = 1'b1;
            end
            LDU_OPC_LINK_D: begin
                dec_size = LDU_SZ_DBL;
                dec_linked = 1'b1;
            end
            LDU_OPC_UPPER: dec_upper = 1'b1;
            default: dec_known = 1'b0;
        endcase
    end

    ldu_addr_gen #(
        .XLEN(XLEN)
    ) u_addr (
        .clk(clk),
        .rst_b(rst_b),
        .base_val(req_base_val),
        .offset(req_offset),
        .size(dec_size),
        .eff_addr(eff_addr),
        .misaligned(misaligned)
    );

    ldu_lane_extract #(
        .XLEN(XLEN)
    ) u_lane (
        .dw(mem_rsp_data),
        .addr_low(ea_reg[2:0]),
        .big_endian(be_reg),
        .size(size_reg),
        .result(lane_result)
    );

    assign upper_value = {{(XLEN-LDU_WORD_BITS){req_offset[LDU_IMM_W-1]}},
        req_offset, {LDU_UPPER_SHIFT{1'b0}}};

    assign req_ready = (state_reg == LDU_ST_IDLE);
    assign take = req_valid && req_ready;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            LDU_ST_IDLE: begin
                if (take) begin
                    if (dec_upper || !dec_known || misaligned) begin
                        state_next = LDU_ST_RESP;
                    end else begin
                        state_next = LDU_ST_REQ;
                    end
                end
            end
            LDU_ST_REQ: begin
                if (mem_req_ready) begin
                    state_next = LDU_ST_WAIT;
                end
            end
            LDU_ST_WAIT: begin
                if (mem_rsp_valid) begin
                    state_next = LDU_ST_RESP;
                end
            end
            LDU_ST_RESP: state_next = LDU_ST_IDLE;
            default: state_next = LDU_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_reg <= LDU_ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Instruction fields held for the whole access.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ea_reg <= '0;
            size_reg <= LDU_SZ_NONE;
            linked_reg <= 1'b0;
            be_reg <= 1'b0;
            rt_reg <= '0;
        end else if (take) begin
            ea_reg <= eff_addr;
            size_reg <= dec_size;
            linked_reg <= dec_linked;
            be_reg <= cpu_byte_order_high_first;
            rt_reg <= req_rt;
        end
    end

    // ------------------------------------------------------------
    // Result and exception capture
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            data_reg <= '0;
            exc_reg <= LDU_EXC_NONE;
        end else if (take) begin
            data_reg <= upper_value;
            if (!dec_known) begin
                exc_reg <= LDU_EXC_RESERVED;
            end else if (dec_upper) begin
                exc_reg <= LDU_EXC_NONE;
            end else if (misaligned) begin
                exc_reg <= LDU_EXC_ADDR;
            end else begin
                exc_reg <= LDU_EXC_NONE;
            end
        end else if (state_reg == LDU_ST_WAIT && mem_rsp_valid) begin
            data_reg <= lane_result;
            if (mem_rsp_refill) begin
                exc_reg <= LDU_EXC_REFILL;
            end else if (mem_rsp_invalid) begin
                exc_reg <= LDU_EXC_INVALID;
            end
        end
    end

    // ------------------------------------------------------------
    // Link flag
    // ------------------------------------------------------------
    // A completing linked load wins over a clear in the same cycle, so
    // the new sequence is never lost; the flag is otherwise left alone
    // until the conditional store side clears it.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            link_reg <= 1'b0;
        end else if (state_reg == LDU_ST_RESP && linked_reg
                && exc_reg == LDU_EXC_NONE) begin
            link_reg <= 1'b1;
        end else if (link_clear) begin
            link_reg <= 1'b0;
        end
    end

    assign link_flag = link_reg;

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign mem_req_valid = (state_reg == LDU_ST_REQ);
    assign mem_vaddr = ea_reg;
    assign mem_size = size_reg;
    assign mem_no_exclusive = linked_reg;
    assign wb_valid = (state_reg == LDU_ST_RESP) && (exc_reg == LDU_EXC_NONE);
    assign wb_rt = rt_reg;
    assign wb_data = data_reg;
    assign exc_valid = (state_reg == LDU_ST_RESP) && (exc_reg != LDU_EXC_NONE);
    assign exc_cause = exc_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_take_upper;
        take && dec_known && dec_upper;
    endsequence

    sequence s_linked_done;
        state_reg == LDU_ST_RESP && linked_reg && !exc_valid;
    endsequence

    chk_upper_imm_value: assert property (
        s_take_upper |=> wb_valid && !exc_valid
            && wb_data[LDU_WORD_BITS-1:0]
                == {$past(req_offset), {LDU_UPPER_SHIFT{1'b0}}}
            && wb_data[XLEN-1] == $past(req_offset[LDU_IMM_W-1]))
        else $error("upper immediate result or exception wrong");

    chk_link_set_flag: assert property (
        s_linked_done |=> link_flag)
        else $error("linked load did not set link flag");

    chk_link_hold_flag: assert property (
        link_flag && !link_clear |=> link_flag)
        else $error("link flag dropped without a clear");

    chk_half_addr_err: assert property (
        take && dec_size == LDU_SZ_HALF && eff_addr[0]
            |=> exc_valid && exc_cause == LDU_EXC_ADDR && !mem_req_valid)
        else $error("odd halfword address did not raise address error");

    chk_dbl_addr_err: assert property (
        take && dec_size == LDU_SZ_DBL && eff_addr[2:0] != 3'h0
            |=> exc_valid && exc_cause == LDU_EXC_ADDR)
        else $error("misaligned doubleword did not raise address error");

    chk_refill_cause: assert property (
        state_reg == LDU_ST_WAIT && mem_rsp_valid && mem_rsp_refill
            |=> exc_valid && exc_cause == LDU_EXC_REFILL && !wb_valid)
        else $error("missing mapping did not raise refill");

    chk_no_excl_link: assert property (
        take && (req_opcode == LDU_OPC_LINK_W
            || req_opcode == LDU_OPC_LINK_D) |=> mem_no_exclusive)
        else $error("linked load may fetch exclusive");

    chk_half_zero_ext: assert property (
        state_reg == LDU_ST_WAIT && mem_rsp_valid
            && size_reg == LDU_SZ_HALF
            |=> wb_data[XLEN-1:LDU_HALF_BITS] == '0)
        else $error("halfword result not zero-extended");

    chk_word_sign_ext: assert property (
        wb_valid && size_reg == LDU_SZ_WORD
            |-> wb_data[XLEN-1:LDU_WORD_BITS]
                == {(XLEN-LDU_WORD_BITS){wb_data[LDU_WORD_BITS-1]}})
        else $error("word result not sign-extended");

    chk_resp_one_cycle: assert property (
        (wb_valid || exc_valid) |=> !wb_valid && !exc_valid && req_ready)
        else $error("answer stood longer than one cycle");

endmodule : ldu_core

// [bench/ldu_mem_model.sv]
module ldu_mem_model
    import ldu_pkg::*;
(
    input wire logic clk, // Core clock.
    input wire logic rst_b, // Synchronous reset, active low.
    input wire logic mem_req_valid, // Request from the unit.
    output logic mem_req_ready, // Request taken.
    input wire logic [63:0] mem_vaddr, // Effective address.
    input wire ldu_size_t mem_size, // Access size.
    input wire logic mem_no_exclusive, // Miss must not fetch exclusive.
    output logic mem_rsp_valid, // Answer pulse.
    output logic [63:0] mem_rsp_data, // Aligned doubleword.
    output logic mem_rsp_refill, // No mapping.
    output logic mem_rsp_invalid, // Mapping invalid.
    input wire logic [1:0] req_lat, // Cycles before ready.
    input wire logic [1:0] rsp_lat, // Cycles before answer.
    input wire logic [63:0] rsp_dw, // Doubleword to return.
    input wire logic want_refill, // Report a missing mapping.
    input wire logic want_invalid, // Report an invalid mapping.
    output logic [63:0] seen_addr, // Address at acceptance.
    output ldu_size_t seen_size, // Size at acceptance.
    output logic seen_noex // No-exclusive flag at acceptance.
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // Translation and cache path
    // ------------------------------------------------------------
    // Outside an answer the data and fault lines carry the inverse of the
    // last value, so a unit that samples them late sees garbage.
    initial begin
        mem_req_ready = 1'b0;
        mem_rsp_valid = 1'b0;
        mem_rsp_data = 64'h0;
        mem_rsp_refill = 1'b0;
        mem_rsp_invalid = 1'b0;
        seen_addr = 64'h0;
        seen_size = LDU_SZ_NONE;
        seen_noex = 1'b0;
        forever begin
            @(posedge clk);
            #1;
            if (rst_b === 1'b1 && mem_req_valid === 1'b1) begin
                repeat (req_lat) begin
                    @(posedge clk);
                    #1;
                end
                mem_req_ready = 1'b1;
                @(posedge clk);
                seen_addr = mem_vaddr;
                seen_size = mem_size;
                seen_noex = mem_no_exclusive;
                #1 mem_req_ready = 1'b0;
                repeat (rsp_lat) begin
                    @(posedge clk);
                    #1;
                end
                mem_rsp_valid = 1'b1;
                mem_rsp_data = rsp_dw;
                mem_rsp_refill = want_refill;
                mem_rsp_invalid = want_invalid;
                @(posedge clk);
                #1;
                mem_rsp_valid = 1'b0;
                mem_rsp_refill = ~want_refill;
                mem_rsp_invalid = ~want_invalid;
            end
            mem_rsp_data = ~mem_rsp_data;
        end
    end
endmodule : ldu_mem_model

// [bench/load_instruction_unit_tb.sv]
module load_instruction_unit_tb
    import ldu_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic is_exc;
        logic [4:0] rt;
        logic [63:0] data;
        ldu_exc_t cause;
    } ldu_exp_t;

    logic clk, rst_b, req_valid, req_ready, be, link_clear, link_flag;
    logic [5:0] req_opcode;
    logic [4:0] req_rt, wb_rt;
    logic [63:0] req_base_val, mem_vaddr, mem_rsp_data, wb_data;
    logic [15:0] req_offset;
    logic mem_req_valid, mem_req_ready, mem_no_exclusive, mem_rsp_valid;
    logic mem_rsp_refill, mem_rsp_invalid, wb_valid, exc_valid;
    ldu_size_t mem_size, seen_size;
    ldu_exc_t exc_cause;
    logic [1:0] req_lat, rsp_lat;
    logic [63:0] rsp_dw, seen_addr;
    logic want_refill, want_invalid, seen_noex, exp_link;
    int fails, n_checks, cyc;
    int seed = 94665;
    ldu_exp_t exp_q[$];
    ldu_exp_t mon_e;
    logic [5:0] ops [6] = '{LDU_OPC_HALF_U, LDU_OPC_WORD, LDU_OPC_LINK_W,
        LDU_OPC_LINK_D, LDU_OPC_UPPER, 6'h3F};

    ldu_core u_ldu_core (.clk(clk), .rst_b(rst_b), .req_valid(req_valid),
        .req_ready(req_ready), .req_opcode(req_opcode), .req_rt(req_rt),
        .req_base_val(req_base_val), .req_offset(req_offset),
        .cpu_byte_order_high_first(be), .mem_req_valid(mem_req_valid),
        .mem_req_ready(mem_req_ready), .mem_vaddr(mem_vaddr),
        .mem_size(mem_size), .mem_no_exclusive(mem_no_exclusive),
        .mem_rsp_valid(mem_rsp_valid), .mem_rsp_data(mem_rsp_data),
        .mem_rsp_refill(mem_rsp_refill), .mem_rsp_invalid(mem_rsp_invalid),
        .wb_valid(wb_valid), .wb_rt(wb_rt), .wb_data(wb_data),
        .exc_valid(exc_valid), .exc_cause(exc_cause),
        .link_clear(link_clear), .link_flag(link_flag));

    ldu_mem_model u_ldu_mem_model (.clk(clk), .rst_b(rst_b),
        .mem_req_valid(mem_req_valid), .mem_req_ready(mem_req_ready),
        .mem_vaddr(mem_vaddr), .mem_size(mem_size),
        .mem_no_exclusive(mem_no_exclusive), .mem_rsp_valid(mem_rsp_valid),
        .mem_rsp_data(mem_rsp_data), .mem_rsp_refill(mem_rsp_refill),
        .mem_rsp_invalid(mem_rsp_invalid), .req_lat(req_lat),
        .rsp_lat(rsp_lat), .rsp_dw(rsp_dw), .want_refill(want_refill),
        .want_invalid(want_invalid), .seen_addr(seen_addr),
        .seen_size(seen_size), .seen_noex(seen_noex));

    always #4 clk = ~clk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish

    task automatic check(input string what, input logic [63:0] exp,
                         input logic [63:0] got);
        n_checks++;
        if (exp !== got) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    function automatic logic [63:0] rnd64();
        return {$random(seed), $random(seed)};
    endfunction : rnd64

    // Works out the answer from the operands, queues it, issues the
    // instruction and waits for the monitor to retire it.
    task automatic run(input logic [5:0] op, input logic [63:0] base,
                       input logic [15:0] off, input logic fr, input logic fi);
        logic [63:0] ea;
        logic [63:0] d;
        logic [2:0] ln;
        logic [2:0] msk;
        logic lnk;
        logic memop;
        int k;
        ldu_size_t sz;
        ldu_exp_t e;
        ea = base + {{48{off[15]}}, off};
        rsp_dw = rnd64();
        want_refill = fr;
        want_invalid = fi;
        req_lat = 2'($random(seed));
        rsp_lat = 2'($random(seed));
        lnk = (op == LDU_OPC_LINK_W) || (op == LDU_OPC_LINK_D);
        case (op)
            LDU_OPC_HALF_U: sz = LDU_SZ_HALF;
            LDU_OPC_WORD, LDU_OPC_LINK_W: sz = LDU_SZ_WORD;
            LDU_OPC_LINK_D: sz = LDU_SZ_DBL;
            default: sz = LDU_SZ_NONE;
        endcase
        msk = (sz == LDU_SZ_HALF) ? 3'h1 : (sz == LDU_SZ_WORD) ? 3'h3 : 3'h7;
        e.rt = 5'($random(seed));
        e.is_exc = 1'b1;
        e.data = 64'h0;
        memop = 1'b0;
        if (op == LDU_OPC_UPPER) begin
            e.is_exc = 1'b0;
            e.cause = LDU_EXC_NONE;
            e.data = {{32{off[15]}}, off, 16'h0};
        end else if (sz == LDU_SZ_NONE) begin
            e.cause = LDU_EXC_RESERVED;
        end else if ((ea[2:0] & msk) != 3'h0) begin
            e.cause = LDU_EXC_ADDR;
        end else begin
            memop = 1'b1;
            e.is_exc = fr | fi;
            e.cause = fr ? LDU_EXC_REFILL : fi ? LDU_EXC_INVALID : LDU_EXC_NONE;
            ln = ea[2:0] ^ ((sz == LDU_SZ_HALF) ? {be, be, 1'b0} : {be, 2'h0});
            d = rsp_dw >> (8 * ln);
            if (sz == LDU_SZ_HALF)
                e.data = {48'h0, d[15:0]};
            else if (sz == LDU_SZ_WORD)
                e.data = {{32{d[31]}}, d[31:0]};
            else
                e.data = rsp_dw;
        end
        exp_q.push_back(e);
        req_valid = 1'b1;
        req_opcode = op;
        req_rt = e.rt;
        req_base_val = base;
        req_offset = off;
        @(posedge clk);
        #1 req_valid = 1'b0;
        k = 0;
        while (exp_q.size() != 0 && k < 40) begin
            @(posedge clk);
            #1;
            k++;
        end
        if (k == 40) begin
            fails++;
            $display("CHECK FAILED answer expected within 40 seen none");
            exp_q.delete();
        end
        if (memop) begin
            check("mem_vaddr", ea, seen_addr);
            check("mem_size", 64'(sz), 64'(seen_size));
            check("mem_no_excl", 64'(lnk),
                64'(seen_noex));
        end
        if (lnk && !e.is_exc)
            exp_link = 1'b1;
        check("link_flag", 64'(exp_link),
            64'(link_flag));
    endtask : run

    task automatic clear_link();
        link_clear = 1'b1;
        @(posedge clk);
        #1 link_clear = 1'b0;
        exp_link = 1'b0;
        check("link_flag", 64'h0, 64'(link_flag));
    endtask : clear_link

    // ------------------------------------------------------------
    // Answer monitor and timeout
    // ------------------------------------------------------------
    // The answer is sampled at the falling edge, where it stands settled,
    // so no race with the rising edge that launches it can arise.
    always @(negedge clk) begin
        if (rst_b === 1'b1 && (wb_valid === 1'b1 || exc_valid === 1'b1)) begin
            if (exp_q.size() == 0) begin
                fails++;
                $display("CHECK FAILED answer expected none seen one");
            end else begin
                mon_e = exp_q.pop_front();
                check("exc_valid", 64'(mon_e.is_exc),
                    64'(exc_valid));
                check("wb_valid", 64'(!mon_e.is_exc),
                    64'(wb_valid));
                if (mon_e.is_exc)
                    check("exc_cause", 64'(mon_e.cause),
                        64'(exc_cause));
                else begin
                    check("wb_rt", 64'(mon_e.rt), 64'(wb_rt));
                    check("wb_data", mon_e.data,
                        wb_data);
                end
            end
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            $display("CHECK FAILED run_cycles expected below 20000 seen 20000");
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        req_valid = 1'b0;
        req_opcode = 6'h00;
        req_rt = 5'h00;
        req_base_val = 64'h0;
        req_offset = 16'h0;
        be = 1'b0;
        link_clear = 1'b0;
        req_lat = 2'h0;
        rsp_lat = 2'h0;
        rsp_dw = 64'h0;
        want_refill = 1'b0;
        want_invalid = 1'b0;
        exp_link = 1'b0;
        fails = 0;
        n_checks = 0;
        cyc = 0;
        repeat (12) @(posedge clk);
        #1 rst_b = 1'b1;
        check("req_ready", 64'h1, 64'(req_ready));
        check("link_flag", 64'h0, 64'(link_flag));
        // Offsets keep their low three bits clear, as software must.
        for (int i = 0; i < 60; i++) begin
            be = i[0];
            run(ops[i % 6], rnd64() & ~64'h7, 16'($random(seed)) & 16'hFFF8,
                1'b0, 1'b0);
        end
        $display("test all_opcodes done");
        // Misalignment comes from the base so that offsets stay legal.
        for (int k = 0; k < 32; k++) begin
            be = k[2];
            run(ops[k % 4], (rnd64() & ~64'h7) | 64'(k / 4), 16'h0008,
                1'b0, 1'b0);
        end
        $display("test alignment done");
        for (int k = 0; k < 12; k++) begin
            run(ops[k % 4], rnd64() & ~64'h7, 16'hFFF0, k / 4 != 1,
                k / 4 != 0);
        end
        $display("test faults done");
        // Linked loads aim only at cached memory; this path is all cached.
        clear_link();
        run(LDU_OPC_LINK_W, rnd64() & ~64'h7, 16'h0, 1'b0, 1'b0);
        clear_link();
        run(LDU_OPC_LINK_D, rnd64() & ~64'h7, 16'h0, 1'b0, 1'b0);
        run(LDU_OPC_LINK_W, rnd64() & ~64'h7, 16'h0, 1'b0, 1'b0);
        run(LDU_OPC_WORD, rnd64() & ~64'h7, 16'h0, 1'b0, 1'b0);
        clear_link();
        run(LDU_OPC_LINK_W, rnd64() & ~64'h7, 16'h0, 1'b1, 1'b0);
        $display("test link_flag done");
        tally_and_finish();
    end
endmodule : load_instruction_unit_tb
